// *** scc_pkg.sv ***
// Package of constants and types for the strap loader and clock-out block
package scc_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [15:0] OUT_CLK_SEL_ADDR = 16'hFF1F;  // Output clock select register
    localparam logic [15:0] OUT_CLK_SEL_RST = 16'h0000;   // Clock output off after reset
    localparam int CLK_SEL_LSB = 0;                       // Source select field position
    localparam int CLK_SEL_W = 3;                         // Source select field width
    localparam int LNK_INV_BIT = 15;                      // Link status invert bit position
    localparam logic [15:0] STRAP_STAT_ADDR = 16'hFF20;   // Latched straps, read only

    // ********************************************************
    // Output clock sources
    // ********************************************************
    localparam logic [2:0] SRC_OFF = 3'h0;       // No clock on the pin
    localparam logic [2:0] SRC_125_FREE = 3'h1;  // 125 MHz free running
    localparam logic [2:0] SRC_125_REC = 3'h2;   // 125 MHz recovered
    localparam logic [2:0] SRC_25 = 3'h3;        // 25 MHz
    localparam logic [2:0] SRC_ADP_FREE = 3'h4;  // 25 or 125 MHz free running
    localparam logic [2:0] SRC_ADP_REC = 3'h5;   // 25 or 125 MHz recovered

    // ********************************************************
    // Strap levels and decoded configuration
    // ********************************************************
    typedef enum logic [1:0] {
        LVL_1 = 2'h0,  // Lowest level
        LVL_2 = 2'h1,  // Above one tenth of supply
        LVL_3 = 2'h2,  // Above one half of supply
        LVL_4 = 2'h3   // Above nine tenths of supply
    } scc_level_t;

    localparam logic [1:0] MACIF_DEFAULT = 2'h0;  // Unstrapped: RGMII with 2 ns delay
    localparam logic [3:0] ADDR_DEFAULT = 4'h0;   // Unstrapped address
    localparam int ROW_W = 4;                     // Width of configuration row number
    localparam logic [3:0] ROW_LAST_AN = 4'hB;    // Last row with autonegotiation on
endpackage : scc_pkg

// *** scc_level_sense.sv ***
// Multilevel comparator: turns a pin level fraction into one of four levels
module scc_level_sense #(
    parameter int FRAC_W = 8  // Width of the sensed supply fraction
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [FRAC_W-1:0] frac_in,
    output scc_pkg::scc_level_t level_out
);
    // ********************************************************
    // Thresholds as fractions of full scale
    // ********************************************************
    localparam int FULL = (1 << FRAC_W) - 1;
    localparam logic [FRAC_W-1:0] TH_LO = FRAC_W'(FULL / 10);       // One tenth
    localparam logic [FRAC_W-1:0] TH_MID = FRAC_W'(FULL / 2);       // One half
    localparam logic [FRAC_W-1:0] TH_HI = FRAC_W'((FULL * 9) / 10); // Nine tenths

    typedef struct packed {
        logic [FRAC_W-1:0] s1;  // First sync stage
        logic [FRAC_W-1:0] s2;  // Second sync stage
        scc_pkg::scc_level_t lvl;
    } st_t;
    st_t st_q;
    st_t st_d;

    // Classify the synchronised level
    always_comb begin
        st_d = st_q;
        st_d.s1 = frac_in;
        st_d.s2 = st_q.s1;
        if (st_q.s2 > TH_HI) begin
            st_d.lvl = scc_pkg::LVL_4;
        end else if (st_q.s2 > TH_MID) begin
            st_d.lvl = scc_pkg::LVL_3;
        end else if (st_q.s2 > TH_LO) begin
            st_d.lvl = scc_pkg::LVL_2;
        end else begin
            st_d.lvl = scc_pkg::LVL_1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule // scc_level_sense

// *** scc_strap_clk.sv ***
// Strap latch, link status driver and auxiliary clock select
// How it works
// - Drive link status pin from link state
// - High by default, invert bit reverses
// - Register selects one clock output source
// - Clock output off after reset
// - Free 125 MHz keeps multiplier powered
// - Sample straps, latch after settling count
// - Multilevel pins decode to four levels
// - Two-level pins: lowest low, highest high
// - Thresholds 0.9, 0.5, 0.1 of supply
// - Four address straps, default zero
// - Two four-level straps set speed options
// - Two straps pick MAC interface type
// - Crossover mode from clock pin strap
// - Power-down strap holds link for software
// - Otherwise bring up link immediately
// - Address straps form binary address
// - Rows one to eleven autonegotiate
// - Both highest: all speeds plus extras
module scc_strap_clk #(
    parameter int FRAC_W = 8,     // Sensed level resolution
    parameter int SETTLE_CYC = 4  // Cycles of sensing after reset before latching
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] addr_strap_in,       // Address straps, two level, synced here
    input wire logic [1:0] mac_if_strap_in,     // MAC interface straps, high then low
    input wire logic [FRAC_W-1:0] speed_strap_high_in, // Level on link status pin
    input wire logic [FRAC_W-1:0] speed_strap_low_in,  // Level on status lamp pin
    input wire logic [FRAC_W-1:0] crossover_strap_in,  // Level on aux clock pin
    input wire logic link_up_in,                // Link engine state, same clock
    input wire logic clk_125_free_in,           // Candidate clocks as sampled levels
    input wire logic clk_125_rec_in,
    input wire logic clk_25_in,
    input wire logic speed_1000_in,             // Selects 125 for adaptive sources
    input wire logic reg_wr_in,                 // Management write strobe
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic link_status_out,
    output logic link_status_oe_out,            // Low while straps are sensed
    output logic aux_clock_out_pin_out,
    output logic aux_clock_oe_out,
    output logic clock_multiplier_unit_on_out,
    output logic [3:0] phy_addr_out,
    output logic [1:0] mac_if_sel_out,
    output logic [1:0] crossover_mode_out,
    output logic [3:0] config_row_out,          // Table row 1..14, 0 when invalid
    output logic autoneg_en_out,
    output logic sw_power_down_out,
    output logic downspeed_en_out,
    output logic energy_detect_sleep_out,
    output logic eee_en_out,
    output logic latched_out
);
    // ********************************************************
    // State
    // ********************************************************
    typedef enum {SENSE, RUN} ph_t;  // Strap phase

    typedef struct packed {
        logic [3:0] a1;        // Address sync stage 1
        logic [3:0] a2;        // Address sync stage 2
        logic [1:0] m1;        // MAC strap sync stage 1
        logic [1:0] m2;        // MAC strap sync stage 2
        logic [7:0] cnt;       // Settling counter
        logic run;             // Straps latched
        logic [3:0] addr;
        logic [1:0] macif;
        logic [1:0] mdix;
        logic [3:0] row;
        logic [15:0] clkcfg;   // Output clock select register
        logic pd;              // Software power-down held
        logic lnk;             // Link status pin level
        logic clk;             // Aux clock pin level
        logic [15:0] rdata;
    } st_t;
    st_t st_q;
    st_t st_d;

    scc_pkg::scc_level_t lvl_hi;
    scc_pkg::scc_level_t lvl_lo;
    scc_pkg::scc_level_t lvl_x;
    logic [3:0] row_c;
    logic [2:0] src;

    // ********************************************************
    // Level sensing
    // ********************************************************
    // four-level decode
    scc_level_sense #(.FRAC_W(FRAC_W)) u_hi (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .frac_in(speed_strap_high_in), .level_out(lvl_hi));
    scc_level_sense #(.FRAC_W(FRAC_W)) u_lo (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .frac_in(speed_strap_low_in), .level_out(lvl_lo));
    scc_level_sense #(.FRAC_W(FRAC_W)) u_x (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .frac_in(crossover_strap_in), .level_out(lvl_x));

    // ********************************************************
    // Configuration row lookup
    // ********************************************************
    // speed strap pair decode
    always_comb begin
        case ({lvl_hi, lvl_lo})
            {scc_pkg::LVL_4, scc_pkg::LVL_4}: row_c = 4'h1;
            {scc_pkg::LVL_1, scc_pkg::LVL_4}: row_c = 4'h2;
            {scc_pkg::LVL_2, scc_pkg::LVL_4}: row_c = 4'h3;
            {scc_pkg::LVL_3, scc_pkg::LVL_4}: row_c = 4'h4;
            {scc_pkg::LVL_4, scc_pkg::LVL_2}: row_c = 4'h5;
            {scc_pkg::LVL_4, scc_pkg::LVL_3}: row_c = 4'h6;
            {scc_pkg::LVL_4, scc_pkg::LVL_1}: row_c = 4'h7;
            {scc_pkg::LVL_3, scc_pkg::LVL_1}: row_c = 4'h8;
            {scc_pkg::LVL_1, scc_pkg::LVL_1}: row_c = 4'h9;
            {scc_pkg::LVL_2, scc_pkg::LVL_1}: row_c = 4'hA;
            {scc_pkg::LVL_3, scc_pkg::LVL_2}: row_c = 4'hB;
            {scc_pkg::LVL_1, scc_pkg::LVL_2}: row_c = 4'hC;
            {scc_pkg::LVL_2, scc_pkg::LVL_2}: row_c = 4'hD;
            {scc_pkg::LVL_3, scc_pkg::LVL_3}: row_c = 4'hE;
            // Combinations outside the table
            default: row_c = 4'h0;
        endcase
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_d = st_q;
        st_d.a1 = addr_strap_in;
        st_d.a2 = st_q.a1;
        st_d.m1 = mac_if_strap_in;
        st_d.m2 = st_q.m1;
        // latch once settling completes after reset
        if (!st_q.run) begin
            if (st_q.cnt == 8'(SETTLE_CYC)) begin
                st_d.run = 1'b1;
                // two-level straps taken as plain bits
                st_d.addr = st_q.a2;
                st_d.macif = st_q.m2;
                st_d.mdix = lvl_x;
                st_d.row = row_c;
                st_d.pd = (row_c == 4'h4);
            end else begin
                st_d.cnt = st_q.cnt + 8'h01;
            end
        end
        // latched fields are not touched in RUN
        if (reg_wr_in && reg_addr_in == scc_pkg::OUT_CLK_SEL_ADDR) begin
            st_d.clkcfg = reg_wdata_in;
        end
        st_d.lnk = link_up_in ^ st_q.clkcfg[scc_pkg::LNK_INV_BIT];
        case (src)
            scc_pkg::SRC_125_FREE: st_d.clk = clk_125_free_in;
            scc_pkg::SRC_125_REC: st_d.clk = clk_125_rec_in;
            scc_pkg::SRC_25: st_d.clk = clk_25_in;
            scc_pkg::SRC_ADP_FREE: st_d.clk = speed_1000_in ? clk_125_free_in : clk_25_in;
            scc_pkg::SRC_ADP_REC: st_d.clk = speed_1000_in ? clk_125_rec_in : clk_25_in;
            default: st_d.clk = 1'b0;
        endcase
        // Register read mux
        if (reg_addr_in == scc_pkg::OUT_CLK_SEL_ADDR) begin
            st_d.rdata = st_q.clkcfg;
        end else if (reg_addr_in == scc_pkg::STRAP_STAT_ADDR) begin
            // Top two bits unused, padded on purpose
            st_d.rdata = {2'h0, st_q.run, st_q.pd, st_q.mdix, st_q.row, st_q.macif, st_q.addr};
        end else begin
            st_d.rdata = 16'h0000;
        end
    end

    assign src = st_q.clkcfg[scc_pkg::CLK_SEL_LSB +: scc_pkg::CLK_SEL_W];

    // State register
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
            st_q.clkcfg <= scc_pkg::OUT_CLK_SEL_RST;
            st_q.addr <= scc_pkg::ADDR_DEFAULT;
            st_q.macif <= scc_pkg::MACIF_DEFAULT;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign reg_rdata_out = st_q.rdata;
    assign link_status_out = st_q.lnk;
    assign link_status_oe_out = st_q.run;
    assign aux_clock_out_pin_out = st_q.clk;
    assign aux_clock_oe_out = st_q.run && (src != scc_pkg::SRC_OFF);
    // multiplier on for free 125 source
    assign clock_multiplier_unit_on_out = st_q.run && (src == scc_pkg::SRC_125_FREE);
    assign phy_addr_out = st_q.addr;
    assign mac_if_sel_out = st_q.macif;
    assign crossover_mode_out = st_q.mdix;
    assign config_row_out = st_q.row;
    assign autoneg_en_out = (st_q.row != 4'h0) && (st_q.row <= scc_pkg::ROW_LAST_AN);
    assign sw_power_down_out = st_q.pd;
    assign downspeed_en_out = (st_q.row == 4'h1);
    assign energy_detect_sleep_out = (st_q.row == 4'h1);
    assign eee_en_out = (st_q.row == 4'h1);
    assign latched_out = st_q.run;
endmodule // scc_strap_clk

// *** scc_strap_clk_asserts.sv ***
// Port checks for the strap loader and clock-out block
module scc_strap_clk_asserts #(
    parameter int SETTLE_CYC = 4
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic link_up_in,
    input wire logic clk_125_free_in,
    input wire logic clk_125_rec_in,
    input wire logic clk_25_in,
    input wire logic speed_1000_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic link_status_out,
    input wire logic aux_clock_out_pin_out,
    input wire logic aux_clock_oe_out,
    input wire logic clock_multiplier_unit_on_out,
    input wire logic [3:0] config_row_out,
    input wire logic autoneg_en_out,
    input wire logic sw_power_down_out,
    input wire logic eee_en_out,
    input wire logic latched_out
);
    // ****
    // Shadow state
    // ****
    logic inv_q;  // Copy of the invert bit
    logic [2:0] src_q;  // Copy of the source code
    logic [7:0] cnt_q;  // Edges since reset release
    logic exp_clk;  // Level the pin should carry
    // Follow register writes, count edges
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            inv_q <= 1'b0;
            src_q <= 3'h0;
            cnt_q <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == scc_pkg::OUT_CLK_SEL_ADDR) begin
                inv_q <= reg_wdata_in[15];
                src_q <= reg_wdata_in[2:0];
            end
            cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
        end
    end
    // Candidate picked by the source code
    always_comb begin
        case (src_q)
            3'h1: exp_clk = clk_125_free_in;
            3'h2: exp_clk = clk_125_rec_in;
            3'h3: exp_clk = clk_25_in;
            3'h4: exp_clk = speed_1000_in ? clk_125_free_in : clk_25_in;
            3'h5: exp_clk = speed_1000_in ? clk_125_rec_in : clk_25_in;
            default: exp_clk = 1'b0;
        endcase
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    property p_lnk; $past(arst_n_in) |-> link_status_out == ($past(link_up_in) ^ $past(inv_q)); endproperty
    a_lnk: assert property (p_lnk) else $error("link level off");
    property p_aux_oe; aux_clock_oe_out == (latched_out && src_q != 3'h0); endproperty
    a_aux_oe: assert property (p_aux_oe) else $error("clock enable off");
    property p_cmu; clock_multiplier_unit_on_out == (latched_out && src_q == 3'h1); endproperty
    a_cmu: assert property (p_cmu) else $error("multiplier power off");
    property p_aux; $past(aux_clock_oe_out) |-> aux_clock_out_pin_out == $past(exp_clk); endproperty
    a_aux: assert property (p_aux) else $error("clock pin source off");
    property p_lat; latched_out == (cnt_q > SETTLE_CYC); endproperty
    a_lat: assert property (p_lat) else $error("latch moment off");
    property p_hold; latched_out && $past(latched_out) |-> $stable(config_row_out); endproperty
    a_hold: assert property (p_hold) else $error("latched row moved");
    property p_an; latched_out |-> autoneg_en_out == (config_row_out inside {[4'h1:4'hB]}); endproperty
    a_an: assert property (p_an) else $error("autoneg off");
    property p_pd; sw_power_down_out == (latched_out && config_row_out == 4'h4); endproperty
    a_pd: assert property (p_pd) else $error("power-down off");
    property p_eee; eee_en_out == (latched_out && config_row_out == 4'h1); endproperty
    a_eee: assert property (p_eee) else $error("eee off");
    c_lat: cover property ($rose(latched_out));
    c_cmu: cover property (clock_multiplier_unit_on_out);
    c_pd: cover property (sw_power_down_out);
endmodule // scc_strap_clk_asserts

bind scc_strap_clk scc_strap_clk_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk_in,
    .arst_n_in, .link_up_in, .clk_125_free_in, .clk_125_rec_in, .clk_25_in, .speed_1000_in,
    .reg_wr_in, .reg_addr_in, .reg_wdata_in, .link_status_out, .aux_clock_out_pin_out,
    .aux_clock_oe_out, .clock_multiplier_unit_on_out, .config_row_out, .autoneg_en_out,
    .sw_power_down_out, .eee_en_out, .latched_out);

// *** scc_far_side.sv ***
// Far side model: link state and candidate clock levels
module scc_far_side (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    output logic link_up_out,
    output logic clk_125_free_out,
    output logic clk_125_rec_out,
    output logic clk_25_out,
    output logic speed_1000_out
);
    logic [7:0] lfsr_q;  // Pattern, every level moves
    // Step the pattern each cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lfsr_q <= 8'hA5;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end
    assign link_up_out = lfsr_q[1];
    assign clk_125_free_out = lfsr_q[0];
    assign clk_125_rec_out = lfsr_q[2];
    assign clk_25_out = lfsr_q[4];
    assign speed_1000_out = lfsr_q[6];
endmodule // scc_far_side

// *** scc_strap_clk_test.sv ***
// Self-checking bench for the strap loader and clock-out block
module scc_strap_clk_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] ROWS = 64'h1657_4EB8_30DA_20C9;  // Row by level pair
    logic ref_clk_in = 1'b0, arst_n_in = 1'b0, reg_wr_in = 1'b0;
    logic [3:0] addr_strap_in = 4'h0, phy_addr_out, config_row_out;
    logic [1:0] mac_if_strap_in = 2'h0, mac_if_sel_out, crossover_mode_out;
    logic [7:0] speed_strap_high_in = 8'h00, speed_strap_low_in = 8'h00;
    logic [7:0] crossover_strap_in = 8'h00;
    logic [15:0] reg_addr_in = 16'h0000, reg_wdata_in = 16'h0000, reg_rdata_out;
    logic link_up_in, clk_125_free_in, clk_125_rec_in, clk_25_in, speed_1000_in;
    logic link_status_out, link_status_oe_out, aux_clock_out_pin_out, aux_clock_oe_out;
    logic clock_multiplier_unit_on_out, autoneg_en_out, sw_power_down_out, downspeed_en_out;
    logic energy_detect_sleep_out, eee_en_out, latched_out;
    int fails = 0, comparisons = 0, cyc = 0;
    scc_far_side far (.ref_clk_in, .arst_n_in, .link_up_out(link_up_in),
        .clk_125_free_out(clk_125_free_in), .clk_125_rec_out(clk_125_rec_in),
        .clk_25_out(clk_25_in), .speed_1000_out(speed_1000_in));
    scc_strap_clk #(.FRAC_W(8), .SETTLE_CYC(4)) dut (.ref_clk_in, .arst_n_in, .addr_strap_in,
        .mac_if_strap_in, .speed_strap_high_in, .speed_strap_low_in, .crossover_strap_in,
        .link_up_in, .clk_125_free_in, .clk_125_rec_in, .clk_25_in, .speed_1000_in, .reg_wr_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .link_status_out, .link_status_oe_out,
        .aux_clock_out_pin_out, .aux_clock_oe_out, .clock_multiplier_unit_on_out, .phy_addr_out,
        .mac_if_sel_out, .crossover_mode_out, .config_row_out, .autoneg_en_out,
        .sw_power_down_out, .downspeed_en_out, .energy_detect_sleep_out, .eee_en_out, .latched_out);
    // Clock, 100 ns period
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // Cut a hang short
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            print_verdict();
        end
    end
    // Count and report one comparison
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
        end
    endtask
    // Random sensed fraction inside one level band
    function automatic logic [7:0] frac(input logic [1:0] l);
        logic [7:0] b [4] = '{8'h00, 8'h1A, 8'h80, 8'hE6};
        logic [7:0] t [4] = '{8'h19, 8'h7F, 8'hE5, 8'hFF};
        return 8'($urandom_range(32'(t[l]), 32'(b[l])));
    endfunction
    // Level the clock pin should carry for source code s, c = {speed, 25, rec, free}
    function automatic logic pick(input int s, input logic [3:0] c);
        logic [5:0] v;
        v = {c[3] ? c[1] : c[2], c[3] ? c[0] : c[2], c[2], c[1], c[0], 1'b0};
        return v[s];
    endfunction
    // One register cycle, read data ready on return
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
        reg_wr_in <= wr;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Every level pair, then register traffic
    initial begin
        logic [1:0] x;
        logic [3:0] a;
        logic [3:0] r;
        logic [3:0] c;
        logic l;
        void'($urandom(57340));
        @(posedge ref_clk_in);
        for (int i = 0; i < 16; i++) begin
            x = 2'($urandom);
            a = (i == 0) ? 4'h0 : 4'($urandom);
            r = ROWS[4 * i +: 4];
            arst_n_in <= 1'b0;
            addr_strap_in <= a;
            mac_if_strap_in <= (i == 0) ? 2'h0 : 2'($urandom);
            speed_strap_high_in <= frac(2'(i >> 2));
            speed_strap_low_in <= frac(2'(i));
            crossover_strap_in <= frac(x);
            repeat (3) @(posedge ref_clk_in);
            arst_n_in <= 1'b1;
            for (int n = 0; n < 20 && latched_out !== 1'b1; n++) @(posedge ref_clk_in);
            check(16'(link_status_oe_out), 16'h0001);
            check(16'(aux_clock_oe_out), 16'h0000);
            check(16'(phy_addr_out), 16'(a));
            check(16'(mac_if_sel_out), 16'(mac_if_strap_in));
            check(16'(crossover_mode_out), 16'(x));
            check(16'(config_row_out), 16'(ROWS[4 * i +: 4]));
            check(16'({downspeed_en_out, energy_detect_sleep_out, eee_en_out}), 16'(7 * (i == 15)));
            check(16'({autoneg_en_out, sw_power_down_out}), 16'({r != 4'h0 && r <= 4'hB, i == 11}));
            addr_strap_in <= ~a;
            speed_strap_high_in <= ~speed_strap_high_in;
            bus(1'b1, 16'hFF20, 16'hFFFF);
            bus(1'b0, 16'hFF20, 16'h0000);
            check(reg_rdata_out, {2'h0, 1'b1, i == 11, x, r, mac_if_strap_in, a});
            bus(1'b0, 16'h0100, 16'h0000);
            check(reg_rdata_out, 16'h0000);
            for (int s = 0; s < 6; s++) begin
                bus(1'b1, 16'hFF1F, {s[0] ^ i[0], 12'h000, 3'(s)});
                bus(1'b0, 16'hFF1F, 16'h0000);
                check(reg_rdata_out, {s[0] ^ i[0], 12'h000, 3'(s)});
                // Inputs as the design samples them at this edge, outputs one edge later
                l = link_up_in;
                c = {speed_1000_in, clk_25_in, clk_125_rec_in, clk_125_free_in};
                @(posedge ref_clk_in);
                check(16'(link_status_out), 16'(l ^ s[0] ^ i[0]));
                check(16'(aux_clock_out_pin_out), 16'(pick(s, c)));
                check(16'({aux_clock_oe_out, clock_multiplier_unit_on_out}), 16'({s != 0, s == 1}));
            end
            $display("test %0d done", i);
        end
        print_verdict();
    end
endmodule // scc_strap_clk_test
